// >>> css_pkg.sv
// Constants shared by the CPU clock source switch
package css_pkg;
	// ----------------------------------------------------------------
	// Bus geometry
	// ----------------------------------------------------------------
	localparam int CSS_AW = 8;
	localparam int CSS_DW = 32;
	localparam logic [1:0] CSS_RESP_OKAY = 2'h0;
	localparam logic [1:0] CSS_RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] CSS_ADDR_MAIN_OSC_CTRL = 8'h00;
	localparam logic [7:0] CSS_ADDR_SLOW_OSC_MODE = 8'h04;
	localparam logic [7:0] CSS_ADDR_MAIN_CLOCK_MODE = 8'h08;
	localparam logic [7:0] CSS_ADDR_CPU_DIVIDER = 8'h0C;
	localparam logic [7:0] CSS_ADDR_CLOCK_STATUS = 8'h10;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CSS_FAST_HALT_BIT = 7;
	localparam int CSS_SLOW_HALT_BIT = 0;
	localparam int CSS_SEL_BIT = 0;
	localparam int CSS_STAT_BIT = 1;
	localparam int CSS_DIV_LSB = 0;
	localparam int CSS_ST_FAST_EN = 0;
	localparam int CSS_ST_SLOW_EN = 1;
	localparam int CSS_ST_SRC_BUSY = 2;
	localparam int CSS_ST_DIV_BUSY = 3;
	localparam int CSS_ST_DIV_LSB = 4;
	localparam int CSS_ST_RUN_LSB = 8;

	// ----------------------------------------------------------------
	// Reset values and timing counts
	// ----------------------------------------------------------------
	localparam logic CSS_SEL_RST = 1'b0;
	localparam logic [2:0] CSS_DIV_RST = 3'h0;
	localparam logic [2:0] CSS_DIV_MAX = 3'h4;
	localparam logic [4:0] CSS_UP_WAIT = 5'h02;
	localparam logic [4:0] CSS_DIV_WAIT_TOP = 5'h10;
	localparam int CSS_RST_HOLD = 17;

	// CPU run phase
	typedef enum logic [1:0]
	{
		CSS_RUN_HOLD = 2'b00,
		CSS_RUN_ACTIVE = 2'b01,
		CSS_RUN_STOP = 2'b10,
		CSS_RUN_HALT = 2'b11
	} css_run_e;
endpackage

// >>> css_clock_switch.sv
// CPU clock source switch with oscillator gating and register slave
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Unstoppable slow oscillator keeps watchdog counting through STOP.
// - After STOP the CPU resumes on the source active at entry.
// - After HALT the CPU resumes on the source active at entry.
// - Fast oscillator halt flag is bit 7 of the main control.
// - Slow oscillator halt flag is bit 0 of its mode register.
// - Slow halt flag acts only when option allows stopping it.
// - Flags 0/0 run both; slow flag alone stops only slow.
// - Fast flag alone stops fast, slow keeps running.
// - Select bit 0 picks slow, 1 picks fast CPU source.
// - Source changeover is deferred; old clock runs a while.
// - Status bit 1 reads the source actually clocking the CPU.
// - Slow to fast in 2 old clocks; fast to slow bounded.
// - Three-bit divider selects division, applied after old clocks.
// - Divider change completes within 16,8,4,2,1 old clocks.
// - Reset selects slow; CPU clock withheld 17 slow clocks.
// - Fast halt flag ignored while CPU uses the fast clock.
// - Slow halt flag ignored while CPU uses the slow clock.
module css_clock_switch
#(
	parameter int RST_HOLD = css_pkg::CSS_RST_HOLD
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic fast_osc_pin,
	input wire logic slow_osc_pin,
	input wire logic slow_osc_stoppable,
	input wire logic stop_req,
	input wire logic halt_req,
	input wire logic wdt_overflow,
	output logic fast_osc_enable,
	output logic slow_osc_enable,
	output logic cpu_clk_pulse,
	output logic periph_clk_pulse,
	output logic wd_count_pulse,
	output logic internal_reset_req,
	output logic cpu_source_status,
	input wire logic [css_pkg::CSS_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [css_pkg::CSS_DW-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [css_pkg::CSS_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [css_pkg::CSS_DW-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import css_pkg::*;

	localparam int HW = $clog2(RST_HOLD + 1);

	// Hold count must fit and be at least one slow clock
	if (RST_HOLD < 1 || RST_HOLD > 255)
	begin : g_bad_hold
		$error("RST_HOLD out of range");
	end

	// ----------------------------------------------------------------
	// Oscillator pin synchronisers and edge detect
	// ----------------------------------------------------------------
	// Pins must toggle slower than mclk/2 or edges are lost
	logic fast_s1_reg, fast_s2_reg, fast_s3_reg;
	logic slow_s1_reg, slow_s2_reg, slow_s3_reg;
	always_ff @(posedge mclk)
	begin
		fast_s1_reg <= fast_osc_pin;
		fast_s2_reg <= fast_s1_reg;
		fast_s3_reg <= fast_s2_reg;
		slow_s1_reg <= slow_osc_pin;
		slow_s2_reg <= slow_s1_reg;
		slow_s3_reg <= slow_s2_reg;
	end
	wire logic fast_edge = fast_s2_reg & ~fast_s3_reg;
	wire logic slow_edge = slow_s2_reg & ~slow_s3_reg;

	// ----------------------------------------------------------------
	// Software control state
	// ----------------------------------------------------------------
	logic fast_halt_reg, slow_halt_reg, sel_reg, act_reg, opt_reg;
	logic [2:0] div_reg, div_act_reg;
	logic [3:0] pre_cnt_reg;
	logic [4:0] sw_cnt_reg, div_cnt_reg;
	logic [HW-1:0] hold_cnt_reg;
	css_run_e run_reg, run_next;

	// Option is caught while reset is asserted and frozen afterwards
	always_ff @(posedge mclk)
	begin
		if (rst)
			opt_reg <= slow_osc_stoppable;
	end

	// ----------------------------------------------------------------
	// Run phase
	// ----------------------------------------------------------------
	wire logic hold_done = (hold_cnt_reg == HW'(RST_HOLD));
	// Requests may overlap, so a strict priority decides: hold, STOP, HALT
	always_comb
	begin
		if (!hold_done)
			run_next = CSS_RUN_HOLD;
		else if (stop_req)
			run_next = CSS_RUN_STOP;
		else if (halt_req)
			run_next = CSS_RUN_HALT;
		else
			run_next = CSS_RUN_ACTIVE;
	end
	wire logic running = (run_reg == CSS_RUN_ACTIVE);

	// Hold counter advances on slow edges after reset release
	always_ff @(posedge mclk)
	begin
		if (rst)
			hold_cnt_reg <= '0;
		else if (slow_edge && !hold_done)
			hold_cnt_reg <= hold_cnt_reg + HW'(1);
	end
	always_ff @(posedge mclk)
	begin
		if (rst)
			run_reg <= CSS_RUN_HOLD;
		else
			run_reg <= run_next;
	end

	// ----------------------------------------------------------------
	// Divided CPU clock
	// ----------------------------------------------------------------
	// CPU ticks are gated off in STOP/HALT so the source is kept
	wire logic src_edge = act_reg ? fast_edge : slow_edge;
	wire logic [4:0] mask5 = (5'h01 << div_act_reg) - 5'h01;
	wire logic [3:0] div_mask = mask5[3:0];
	wire logic div_hit = ((pre_cnt_reg & div_mask) == div_mask);
	wire logic cpu_tick = src_edge & div_hit & running;

	// Changeover pending and completion
	wire logic src_pend = (sel_reg != act_reg);
	wire logic up_done = src_pend & !act_reg & cpu_tick
		& (sw_cnt_reg == CSS_UP_WAIT - 5'h01);
	wire logic down_done = src_pend & act_reg & running & slow_edge
		& (sw_cnt_reg != 5'h00);
	wire logic src_done = up_done | down_done;
	wire logic div_pend = (div_reg != div_act_reg);
	wire logic [4:0] div_wait = CSS_DIV_WAIT_TOP >> div_act_reg;
	wire logic div_done = div_pend & cpu_tick
		& (div_cnt_reg == div_wait - 5'h01);

	// Prescaler restarts on every change to keep the first period whole
	always_ff @(posedge mclk)
	begin
		if (rst || src_done || div_done)
			pre_cnt_reg <= 4'h0;
		else if (src_edge)
			pre_cnt_reg <= pre_cnt_reg + 4'h1;
	end

	// Old-clock counters for source and divider changes
	always_ff @(posedge mclk)
	begin
		if (rst || !src_pend || src_done)
			sw_cnt_reg <= 5'h00;
		else if (cpu_tick && sw_cnt_reg != 5'h1F)
			sw_cnt_reg <= sw_cnt_reg + 5'h01;
	end
	always_ff @(posedge mclk)
	begin
		if (rst || !div_pend || div_done)
			div_cnt_reg <= 5'h00;
		else if (cpu_tick)
			div_cnt_reg <= div_cnt_reg + 5'h01;
	end

	// Active source and divider move only at completion
	always_ff @(posedge mclk)
	begin
		if (rst)
			act_reg <= CSS_SEL_RST;
		else if (src_done)
			act_reg <= sel_reg;
	end
	always_ff @(posedge mclk)
	begin
		if (rst)
			div_act_reg <= CSS_DIV_RST;
		else if (div_done)
			div_act_reg <= div_reg;
	end

	// ----------------------------------------------------------------
	// Oscillator gating and clock outputs
	// ----------------------------------------------------------------
	// A source in use or pending keeps running whatever its flag says
	wire logic fast_in_use = act_reg | sel_reg;
	wire logic slow_in_use = !act_reg | !sel_reg;
	wire logic slow_gate = opt_reg & slow_halt_reg & !slow_in_use;
	wire logic fast_en_next = (run_reg != CSS_RUN_STOP)
		& !(fast_halt_reg & !fast_in_use);
	wire logic slow_en_next = !slow_gate;
	wire logic low_power = (run_reg == CSS_RUN_STOP)
		| (run_reg == CSS_RUN_HALT);
	wire logic periph_src = (run_reg == CSS_RUN_HALT) ? sel_reg : act_reg;
	wire logic periph_next = (periph_src ? fast_edge : slow_edge)
		& (run_reg != CSS_RUN_STOP)
		& (run_reg != CSS_RUN_HOLD);
	wire logic wd_next = slow_edge & slow_osc_enable
		& !(opt_reg & low_power);

	// Registered outputs; all quiet while reset is asserted
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			fast_osc_enable <= 1'b0;
			slow_osc_enable <= 1'b0;
			cpu_clk_pulse <= 1'b0;
			periph_clk_pulse <= 1'b0;
			wd_count_pulse <= 1'b0;
			internal_reset_req <= 1'b0;
		end
		else
		begin
			fast_osc_enable <= fast_en_next;
			slow_osc_enable <= slow_en_next;
			cpu_clk_pulse <= cpu_tick;
			periph_clk_pulse <= periph_next;
			wd_count_pulse <= wd_next;
			internal_reset_req <= wdt_overflow;
		end
	end
	assign cpu_source_status = act_reg;

	// ----------------------------------------------------------------
	// Register bus slave
	// ----------------------------------------------------------------
	logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
	logic [CSS_AW-1:0] aw_addr_reg;
	logic [CSS_DW-1:0] w_data_reg, rdata_reg;
	logic w_lane_reg;
	logic [1:0] bresp_reg, rresp_reg;

	assign s_axi_awready = !aw_held_reg & !bvalid_reg;
	assign s_axi_wready = !w_held_reg & !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	wire logic aw_take = s_axi_awvalid & s_axi_awready;
	wire logic w_take = s_axi_wvalid & s_axi_wready;
	wire logic do_write = (aw_held_reg | aw_take) & (w_held_reg | w_take);
	wire logic [CSS_AW-1:0] wr_addr = aw_held_reg ? aw_addr_reg
		: s_axi_awaddr;
	wire logic [CSS_DW-1:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
	wire logic wr_lane = w_held_reg ? w_lane_reg : s_axi_wstrb[0];
	wire logic [5:0] wr_word = wr_addr[7:2];
	wire logic we_moc = do_write & wr_lane
		& (wr_word == CSS_ADDR_MAIN_OSC_CTRL[7:2]);
	wire logic we_rcm = do_write & wr_lane
		& (wr_word == CSS_ADDR_SLOW_OSC_MODE[7:2]);
	wire logic we_mcm = do_write & wr_lane
		& (wr_word == CSS_ADDR_MAIN_CLOCK_MODE[7:2]);
	wire logic we_div = do_write & wr_lane
		& (wr_word == CSS_ADDR_CPU_DIVIDER[7:2]);
	wire logic wr_mapped = (wr_word <= CSS_ADDR_CLOCK_STATUS[7:2]);
	// Codes above the largest division are clamped to it
	wire logic [2:0] div_wr = wr_data[CSS_DIV_LSB +: 3];
	wire logic [2:0] div_clamped = (div_wr > CSS_DIV_MAX) ? CSS_DIV_MAX
		: div_wr;

	// Write channel capture and response
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= CSS_RESP_OKAY;
		end
		else if (do_write)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_mapped ? CSS_RESP_OKAY : CSS_RESP_SLVERR;
		end
		else
		begin
			aw_held_reg <= aw_held_reg | aw_take;
			w_held_reg <= w_held_reg | w_take;
			bvalid_reg <= bvalid_reg & !s_axi_bready;
		end
	end
	always_ff @(posedge mclk)
	begin
		if (aw_take)
			aw_addr_reg <= s_axi_awaddr;
		if (w_take)
		begin
			w_data_reg <= s_axi_wdata;
			w_lane_reg <= s_axi_wstrb[0];
		end
	end
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	// Control registers written by software
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			fast_halt_reg <= 1'b0;
			slow_halt_reg <= 1'b0;
			sel_reg <= CSS_SEL_RST;
			div_reg <= CSS_DIV_RST;
		end
		else
		begin
			if (we_moc)
				fast_halt_reg <= wr_data[CSS_FAST_HALT_BIT];
			if (we_rcm)
				slow_halt_reg <= wr_data[CSS_SLOW_HALT_BIT];
			if (we_mcm)
				sel_reg <= wr_data[CSS_SEL_BIT];
			if (we_div)
				div_reg <= div_clamped;
		end
	end

	// Read decode; status bit 1 shows the completed source
	wire logic [5:0] rd_word = s_axi_araddr[7:2];
	wire logic [CSS_DW-1:0] rd_moc = 32'(fast_halt_reg) << CSS_FAST_HALT_BIT;
	wire logic [CSS_DW-1:0] rd_rcm = 32'(slow_halt_reg) << CSS_SLOW_HALT_BIT;
	wire logic [CSS_DW-1:0] rd_mcm = (32'(sel_reg) << CSS_SEL_BIT)
		| (32'(act_reg) << CSS_STAT_BIT);
	wire logic [CSS_DW-1:0] rd_div = 32'(div_reg) << CSS_DIV_LSB;
	wire logic [CSS_DW-1:0] rd_st = (32'(fast_osc_enable) << CSS_ST_FAST_EN)
		| (32'(slow_osc_enable) << CSS_ST_SLOW_EN)
		| (32'(src_pend) << CSS_ST_SRC_BUSY)
		| (32'(div_pend) << CSS_ST_DIV_BUSY)
		| (32'(div_act_reg) << CSS_ST_DIV_LSB)
		| (32'(run_reg) << CSS_ST_RUN_LSB);
	wire logic rd_hit_moc = (rd_word == CSS_ADDR_MAIN_OSC_CTRL[7:2]);
	wire logic rd_hit_rcm = (rd_word == CSS_ADDR_SLOW_OSC_MODE[7:2]);
	wire logic rd_hit_mcm = (rd_word == CSS_ADDR_MAIN_CLOCK_MODE[7:2]);
	wire logic rd_hit_div = (rd_word == CSS_ADDR_CPU_DIVIDER[7:2]);
	wire logic rd_hit_st = (rd_word == CSS_ADDR_CLOCK_STATUS[7:2]);
	wire logic rd_mapped = rd_hit_moc | rd_hit_rcm | rd_hit_mcm
		| rd_hit_div | rd_hit_st;
	wire logic [CSS_DW-1:0] rd_mux = ({CSS_DW{rd_hit_moc}} & rd_moc)
		| ({CSS_DW{rd_hit_rcm}} & rd_rcm)
		| ({CSS_DW{rd_hit_mcm}} & rd_mcm)
		| ({CSS_DW{rd_hit_div}} & rd_div)
		| ({CSS_DW{rd_hit_st}} & rd_st);

	// Read data is captured when the address is taken
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= CSS_RESP_OKAY;
		end
		else if (s_axi_arvalid && !rvalid_reg)
		begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_mux;
			rresp_reg <= rd_mapped ? CSS_RESP_OKAY : CSS_RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_reg <= 1'b0;
	end
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
endmodule

`default_nettype wire

// >>> css_clock_switch_properties.sv
// Port-level checker for the CPU clock source switch
`timescale 1ns/10ps
`default_nettype none
module css_clock_switch_properties
#(
	parameter int RST_HOLD = css_pkg::CSS_RST_HOLD
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic stop_req,
	input wire logic halt_req,
	input wire logic wdt_overflow,
	input wire logic fast_osc_enable,
	input wire logic slow_osc_enable,
	input wire logic cpu_clk_pulse,
	input wire logic periph_clk_pulse,
	input wire logic internal_reset_req,
	input wire logic cpu_source_status,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid
);
	import css_pkg::*;
	// ----------------------------------------------------------------
	// Clock domain and reset
	// ----------------------------------------------------------------
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Neither oscillator nor the CPU clock may run on the first edge after a reset
	a_reset_quiet: assert property ($fell(rst)
		|-> !fast_osc_enable && !slow_osc_enable
		&& !cpu_clk_pulse && !cpu_source_status)
		else $error("outputs active right after reset");
	a_wdt_reset_follow: assert property (!$past(rst)
		|-> internal_reset_req == $past(wdt_overflow))
		else $error("overflow did not reach internal reset");
	// Three cycles of STOP leave no CPU or peripheral clock and no fast oscillator running
	a_stop_gates: assert property (stop_req
		&& $past(stop_req) && $past(stop_req, 2)
		|-> !cpu_clk_pulse && !periph_clk_pulse && !fast_osc_enable)
		else $error("clock running in stop");
	a_stop_keeps_source: assert property (stop_req
		&& $past(stop_req)
		|-> $stable(cpu_source_status))
		else $error("source changed in stop");
	a_halt_keeps_source: assert property (halt_req
		&& $past(halt_req) && $past(halt_req, 2)
		|-> $stable(cpu_source_status) && !cpu_clk_pulse)
		else $error("source changed or cpu clocked in halt");
	// The oscillator feeding the CPU may be stopped only by STOP
	a_fast_kept_running: assert property (cpu_source_status
		&& !stop_req && !$past(stop_req) && !$past(stop_req, 2)
		|-> fast_osc_enable)
		else $error("fast oscillator stopped under the cpu");
	a_slow_kept_running: assert property (!cpu_source_status
		&& !$past(cpu_source_status) && !$past(rst)
		|-> slow_osc_enable)
		else $error("slow oscillator stopped under the cpu");
	a_switch_to_live: assert property ($rose(cpu_source_status)
		|-> fast_osc_enable && $past(fast_osc_enable))
		else $error("status moved to a stopped source");
	a_read_answered: assert property (s_axi_arvalid
		&& s_axi_arready
		|=> s_axi_rvalid)
		else $error("read not answered next cycle");
	// ----------------------------------------------------------------
	// Coverage
	// ----------------------------------------------------------------
	c_to_fast: cover property ($rose(cpu_source_status));
	c_to_slow: cover property ($fell(cpu_source_status));
	c_halt_periph: cover property (halt_req && periph_clk_pulse);
endmodule
bind css_clock_switch css_clock_switch_properties #(.RST_HOLD(RST_HOLD))
	u_props (.mclk, .rst, .stop_req, .halt_req, .wdt_overflow,
	.fast_osc_enable, .slow_osc_enable, .cpu_clk_pulse,
	.periph_clk_pulse, .internal_reset_req, .cpu_source_status,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire

// >>> css_clock_switch_tb_top.sv
// Self-checking bench for the CPU clock source switch
`timescale 1ns/10ps
`default_nettype none
module css_clock_switch_tb_top;
	import css_pkg::*;
	logic mclk, rst, fast_osc_pin, slow_osc_pin, slow_osc_stoppable;
	logic stop_req, halt_req, wdt_overflow, fast_osc_enable, slow_osc_enable;
	logic cpu_clk_pulse, periph_clk_pulse, wd_count_pulse;
	logic internal_reset_req, cpu_source_status;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [31:0] q;
	logic [1:0] r;
	int err_total, comparisons, nc, np, nw, g;

	// Short hold count keeps the start-up wait brief
	css_clock_switch #(.RST_HOLD(2)) dut (.mclk, .rst, .fast_osc_pin,
		.slow_osc_pin, .slow_osc_stoppable, .stop_req, .halt_req,
		.wdt_overflow, .fast_osc_enable, .slow_osc_enable, .cpu_clk_pulse,
		.periph_clk_pulse, .wd_count_pulse, .internal_reset_req,
		.cpu_source_status, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);

	// ----------------------------------------------------------------
	// Clock and oscillators
	// ----------------------------------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Oscillators only swing while enabled, as a stopped one would
	always #20 if (fast_osc_enable === 1'b1) fast_osc_pin = ~fast_osc_pin;
	always #100 if (slow_osc_enable === 1'b1) slow_osc_pin = ~slow_osc_pin;

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h",
				$time, got, exp);
		end
	endtask

	// One bus transfer; each channel is dropped at the edge that took it
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		logic da;
		logic dw;
		logic dv;
		logic ta;
		logic tw;
		@(posedge mclk);
		da = 1'b0;
		dw = !wr;
		dv = 1'b0;
		if (wr)
		begin
			s_axi_awaddr <= a;
			s_axi_awvalid <= 1'b1;
			s_axi_wdata <= d;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
		end
		else
		begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
		end
		while (!dv)
		begin
			@(negedge mclk);
			q = s_axi_rdata;
			r = wr ? s_axi_bresp : s_axi_rresp;
			dv = da && dw && (wr ? s_axi_bvalid : s_axi_rvalid);
			ta = wr ? s_axi_awvalid && s_axi_awready
				: s_axi_arvalid && s_axi_arready;
			tw = wr && s_axi_wvalid && s_axi_wready;
			@(posedge mclk);
			if (ta && wr)
				s_axi_awvalid <= 1'b0;
			if (ta && !wr)
				s_axi_arvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			da = da | ta;
			dw = dw | tw;
		end
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
		input logic [1:0] rexp);
		xfer(1'b0, a, 32'h0);
		chk(q, exp);
		chk({30'h0, r}, {30'h0, rexp});
	endtask

	task automatic wait_stat(input logic v);
		int n;
		n = 0;
		while (cpu_source_status !== v && n < 60)
		begin
			@(negedge mclk);
			n++;
		end
	endtask

	task automatic count(input int cyc);
		nc = 0;
		np = 0;
		nw = 0;
		repeat (cyc)
		begin
			@(negedge mclk);
			nc += (cpu_clk_pulse === 1'b1);
			np += (periph_clk_pulse === 1'b1);
			nw += (wd_count_pulse === 1'b1);
		end
	endtask

	task automatic do_reset(input logic o);
		@(posedge mclk);
		rst <= 1'b1;
		slow_osc_stoppable <= o;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
	endtask

	task automatic settle;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------
	initial
	begin
		#100000;
		err_total++;
		report_and_stop;
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial
	begin
		{rst, fast_osc_pin, slow_osc_pin, stop_req, halt_req} = 5'b10000;
		{wdt_overflow, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready} = 2'b00;
		slow_osc_stoppable = 1'b1;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		err_total = 0;
		comparisons = 0;
		do_reset(1'b1);
		count(30);
		chk(nc, 0);
		rd_chk(CSS_ADDR_MAIN_OSC_CTRL, 32'h0, CSS_RESP_OKAY);
		rd_chk(CSS_ADDR_SLOW_OSC_MODE, 32'h0, CSS_RESP_OKAY);
		rd_chk(CSS_ADDR_MAIN_CLOCK_MODE, 32'h0, CSS_RESP_OKAY);
		rd_chk(CSS_ADDR_CPU_DIVIDER, 32'h0, CSS_RESP_OKAY);
		rd_chk(8'h14, 32'h0, CSS_RESP_SLVERR);
		xfer(1'b1, 8'h20, 32'h1);
		chk({30'h0, r}, {30'h0, CSS_RESP_SLVERR});
		// Status bit is read-only
		xfer(1'b1, CSS_ADDR_MAIN_CLOCK_MODE, 32'h2);
		rd_chk(CSS_ADDR_MAIN_CLOCK_MODE, 32'h0, CSS_RESP_OKAY);
		// Fast halt flag acts while the CPU runs slow
		chk(cpu_source_status, 0);
		xfer(1'b1, CSS_ADDR_MAIN_OSC_CTRL, 32'hFF);
		rd_chk(CSS_ADDR_MAIN_OSC_CTRL, 32'h80, CSS_RESP_OKAY);
		settle;
		chk({fast_osc_enable, slow_osc_enable}, 2'b01);
		xfer(1'b1, CSS_ADDR_MAIN_OSC_CTRL, 32'h0);
		xfer(1'b1, CSS_ADDR_SLOW_OSC_MODE, 32'hFF);
		rd_chk(CSS_ADDR_SLOW_OSC_MODE, 32'h1, CSS_RESP_OKAY);
		settle;
		chk({fast_osc_enable, slow_osc_enable}, 2'b11);
		xfer(1'b1, CSS_ADDR_SLOW_OSC_MODE, 32'h0);
		count(40);
		chk(nc, 2);
		// Move onto the fast clock; changeover is deferred
		xfer(1'b1, CSS_ADDR_MAIN_CLOCK_MODE, 32'h1);
		rd_chk(CSS_ADDR_MAIN_CLOCK_MODE, 32'h1, CSS_RESP_OKAY);
		wait_stat(1'b1);
		chk(cpu_source_status, 1);
		rd_chk(CSS_ADDR_MAIN_CLOCK_MODE, 32'h3, CSS_RESP_OKAY);
		xfer(1'b1, CSS_ADDR_MAIN_OSC_CTRL, 32'h80);
		settle;
		chk(fast_osc_enable, 1);
		xfer(1'b1, CSS_ADDR_MAIN_OSC_CTRL, 32'h0);
		xfer(1'b1, CSS_ADDR_SLOW_OSC_MODE, 32'h1);
		settle;
		chk(slow_osc_enable, 0);
		xfer(1'b1, CSS_ADDR_SLOW_OSC_MODE, 32'h0);
		settle;
		chk(slow_osc_enable, 1);
		// Divider change waits for sixteen old CPU clocks
		xfer(1'b1, CSS_ADDR_CPU_DIVIDER, 32'h1);
		rd_chk(CSS_ADDR_CLOCK_STATUS, 32'h10B, CSS_RESP_OKAY);
		repeat (80) @(posedge mclk);
		rd_chk(CSS_ADDR_CLOCK_STATUS, 32'h113, CSS_RESP_OKAY);
		do @(negedge mclk); while (cpu_clk_pulse !== 1'b1);
		g = 0;
		do
		begin
			@(negedge mclk);
			g++;
		end
		while (cpu_clk_pulse !== 1'b1);
		chk(g, 8);
		// STOP freezes CPU, peripheral and watchdog clocks and the fast oscillator; resumes on the fast clock
		@(posedge mclk);
		stop_req <= 1'b1;
		repeat (5) @(posedge mclk);
		rd_chk(CSS_ADDR_CLOCK_STATUS, 32'h212, CSS_RESP_OKAY);
		count(20);
		chk({nc[15:0], np[15:0]}, 32'h0);
		chk(nw, 0);
		@(posedge mclk);
		stop_req <= 1'b0;
		settle;
		chk(cpu_source_status, 1);
		// HALT keeps the peripheral clock on the selected source
		@(posedge mclk);
		halt_req <= 1'b1;
		repeat (5) @(posedge mclk);
		rd_chk(CSS_ADDR_CLOCK_STATUS, 32'h313, CSS_RESP_OKAY);
		count(20);
		chk({nc[15:0], np[15:0]}, 32'h5);
		@(posedge mclk);
		halt_req <= 1'b0;
		settle;
		chk(cpu_source_status, 1);
		@(posedge mclk);
		wdt_overflow <= 1'b1;
		@(posedge mclk);
		wdt_overflow <= 1'b0;
		@(negedge mclk);
		chk(internal_reset_req, 1);
		// Back to the slow clock
		xfer(1'b1, CSS_ADDR_MAIN_CLOCK_MODE, 32'h0);
		wait_stat(1'b0);
		chk(cpu_source_status, 0);
		// Option forbids stopping the slow oscillator
		do_reset(1'b0);
		repeat (60) @(posedge mclk);
		xfer(1'b1, CSS_ADDR_MAIN_CLOCK_MODE, 32'h1);
		wait_stat(1'b1);
		xfer(1'b1, CSS_ADDR_SLOW_OSC_MODE, 32'h1);
		settle;
		chk({cpu_source_status, slow_osc_enable}, 2'b11);
		// Unstoppable slow oscillator keeps the watchdog fed in STOP
		@(posedge mclk);
		stop_req <= 1'b1;
		count(40);
		chk(nw, 2);
		chk(slow_osc_enable, 1);
		report_and_stop;
	end
endmodule
`default_nettype wire
